// ===== include/pin_router_pkg.sv
// Constants for the peripheral pin router
// Functional notes
// - Op-amp select bit picks port 3 pin 0/1
// - Op-amp output drives no pin unless enabled
// - Comparator connects to pins only when enabled
// - Capture field picks pair; input one even
// - PWM field picks pair; each output gated
// - Two-wire clock even pin, data odd pin
// - Two-wire lines connect only when enabled
// - Serial-peripheral group of four, select order
// - Serial-peripheral signals connect only when enabled
// - Async serial transmit even, receive odd pin
// - Async serial connects only when enabled
// - Lowest priority number wins a shared pin
package pin_router_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PAIR_PINS = 16;
  localparam int PORT_W = 8;
  localparam int SEL_W = 3;
  localparam int GRP_W = 2;

  // Register offsets
  localparam logic [7:0] PORT1_CTRL_OFS = 8'h00;
  localparam logic [7:0] PORT2_CTRL_OFS = 8'h04;
  localparam logic [7:0] PORT3_CTRL_OFS = 8'h08;
  localparam logic [7:0] PIN_STATE_OFS = 8'h0C;
  localparam logic [7:0] ROUTE_CTRL_A_OFS = 8'h40;
  localparam logic [7:0] ROUTE_CTRL_B_OFS = 8'h44;

  // Port control fields
  localparam int PORT_OE_LSB = 0;
  localparam int PORT_DO_LSB = 8;
  localparam int PORT_PU_LSB = 16;
  localparam logic [31:0] PORT_WR_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] PORT_CTRL_RST = 32'h0000_0000;

  // route_ctrl_a fields
  localparam int OPAMP_SEL_BIT = 19;
  localparam int OPAMP_EN_BIT = 18;
  localparam int CMP_EN_BIT = 16;
  localparam int CAP_SEL_LSB = 5;
  localparam int PWM_SEL_LSB = 2;
  localparam int PWM1_EN_BIT = 1;
  localparam int PWM0_EN_BIT = 0;
  localparam logic [31:0] ROUTE_A_WR_MASK = 32'h000D_00FF;
  localparam logic [31:0] ROUTE_A_RST = 32'h0000_0000;

  // route_ctrl_b fields
  localparam int TW_SEL_LSB = 17;
  localparam int TW_EN_BIT = 16;
  localparam int SPI_SEL_LSB = 5;
  localparam int SPI_EN_BIT = 4;
  localparam int UART_SEL_LSB = 1;
  localparam int UART_EN_BIT = 0;
  localparam logic [31:0] ROUTE_B_WR_MASK = 32'h000F_007F;
  localparam logic [31:0] ROUTE_B_RST = 32'h0000_0000;

  // Fixed pins and masks
  localparam logic [15:0] CMP_PIN_MASK = 16'h00FF;
  localparam int CMP_OUT_PIN = 7;
  localparam logic [15:0] PAIR_BASE = 16'h0001;
  localparam logic [15:0] GROUP_BASE = 16'h000F;

  // Values seen by a peripheral while it is not routed; capture has no enable and sees CAP_IDLE only in reset
  localparam logic TW_IDLE = 1'b1;
  localparam logic UART_RX_IDLE = 1'b1;
  localparam logic CAP_IDLE = 1'b0;
  localparam logic [3:0] SPI_IDLE = 4'h1;
endpackage : pin_router_pkg

// ===== rtl/pad_sync.sv
// Two-flop synchroniser for pad inputs
`timescale 1ns/1ps
module pad_sync #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds the second only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : pad_sync

// ===== rtl/pin_drive_arbiter.sv
// Per-pin priority pick among routed drivers
`timescale 1ns/1ps
module pin_drive_arbiter #(
  parameter int PINS = 16
) (
  // Serial peripheral, rank 1
  input wire logic [PINS-1:0] spi_claim,
  input wire logic [PINS-1:0] spi_out,
  input wire logic [PINS-1:0] spi_oe,
  // Two-wire, rank 2
  input wire logic [PINS-1:0] tw_claim,
  input wire logic [PINS-1:0] tw_out,
  input wire logic [PINS-1:0] tw_oe,
  // Async serial, rank 3
  input wire logic [PINS-1:0] uart_claim,
  input wire logic [PINS-1:0] uart_out,
  input wire logic [PINS-1:0] uart_oe,
  // Comparator, rank 4
  input wire logic [PINS-1:0] cmp_claim,
  input wire logic [PINS-1:0] cmp_out,
  input wire logic [PINS-1:0] cmp_oe,
  // PWM, rank 5
  input wire logic [PINS-1:0] pwm_claim,
  input wire logic [PINS-1:0] pwm_out,
  // Ordinary port
  input wire logic [PINS-1:0] gpio_out,
  input wire logic [PINS-1:0] gpio_oe,
  // Result
  output logic [PINS-1:0] drive_out,
  output logic [PINS-1:0] drive_oe,
  output logic [PINS-1:0] claimed
);
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      // Lower rank number checked first
      assign drive_out[i] = spi_claim[i] ? spi_out[i] :
                            tw_claim[i] ? tw_out[i] :
                            uart_claim[i] ? uart_out[i] :
                            cmp_claim[i] ? cmp_out[i] :
                            pwm_claim[i] ? pwm_out[i] :
                            gpio_out[i];
      assign drive_oe[i] = spi_claim[i] ? spi_oe[i] :
                           tw_claim[i] ? tw_oe[i] :
                           uart_claim[i] ? uart_oe[i] :
                           cmp_claim[i] ? cmp_oe[i] :
                           pwm_claim[i] ? 1'b1 :
                           gpio_oe[i];
      assign claimed[i] = spi_claim[i] | tw_claim[i] | uart_claim[i] |
                          cmp_claim[i] | pwm_claim[i];
    end
  endgenerate
endmodule : pin_drive_arbiter

// ===== rtl/peripheral_pin_router.sv
// Peripheral to port pin router with its register file
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module peripheral_pin_router (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [pin_router_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pin_router_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pin_router_pkg::DATA_W-1:0] reg_rdata,
  // Port 1 and 2 pads, port 1 in the low byte
  input wire logic [15:0] pad12_in,
  output logic [15:0] pad12_out,
  output logic [15:0] pad12_oe,
  output logic [15:0] pad12_pullup,
  // Port 3 pads
  input wire logic [7:0] pad3_in,
  output logic [7:0] pad3_out,
  output logic [7:0] pad3_oe,
  output logic [7:0] pad3_pullup,
  // Op-amp digital output
  input wire logic opamp_dig_out,
  // Comparator
  input wire logic comparator_out,
  output logic [7:0] comparator_pad_connect,
  // Capture timer
  output logic capture_input_one,
  output logic capture_input_two,
  // PWM timer
  input wire logic pwm_output_zero,
  input wire logic pwm_output_one,
  // Two-wire: bit 0 clock, bit 1 data
  input wire logic [1:0] twowire_out,
  input wire logic [1:0] twowire_oe,
  output logic [1:0] twowire_in,
  // Serial peripheral: select, clock, miso, mosi
  input wire logic [3:0] serial_periph_out,
  input wire logic [3:0] serial_periph_oe,
  output logic [3:0] serial_periph_in,
  // Async serial unit
  input wire logic async_serial_tx,
  output logic async_serial_rx
);
  import pin_router_pkg::*;

  logic [31:0] port1_ctrl_ff;
  logic [31:0] port2_ctrl_ff;
  logic [31:0] port3_ctrl_ff;
  logic [31:0] route_ctrl_a_ff;
  logic [31:0] route_ctrl_b_ff;
  logic [31:0] rdata_ff;

  // Register decode
  wire sel_p1 = (reg_addr == PORT1_CTRL_OFS);
  wire sel_p2 = (reg_addr == PORT2_CTRL_OFS);
  wire sel_p3 = (reg_addr == PORT3_CTRL_OFS);
  wire sel_state = (reg_addr == PIN_STATE_OFS);
  wire sel_a = (reg_addr == ROUTE_CTRL_A_OFS);
  wire sel_b = (reg_addr == ROUTE_CTRL_B_OFS);

  wire wr_p1 = reg_wr & sel_p1;
  wire wr_p2 = reg_wr & sel_p2;
  wire wr_p3 = reg_wr & sel_p3;
  wire wr_a = reg_wr & sel_a;
  wire wr_b = reg_wr & sel_b;

  // Only defined bits store; the rest read back as zero
  wire [31:0] nxt_port1_ctrl = wr_p1 ? (reg_wdata & PORT_WR_MASK) : port1_ctrl_ff;
  wire [31:0] nxt_port2_ctrl = wr_p2 ? (reg_wdata & PORT_WR_MASK) : port2_ctrl_ff;
  wire [31:0] nxt_port3_ctrl = wr_p3 ? (reg_wdata & PORT_WR_MASK) : port3_ctrl_ff;
  wire [31:0] nxt_route_ctrl_a = wr_a ? (reg_wdata & ROUTE_A_WR_MASK) : route_ctrl_a_ff;
  wire [31:0] nxt_route_ctrl_b = wr_b ? (reg_wdata & ROUTE_B_WR_MASK) : route_ctrl_b_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port1_ctrl_ff <= PORT_CTRL_RST;
      port2_ctrl_ff <= PORT_CTRL_RST;
      port3_ctrl_ff <= PORT_CTRL_RST;
      route_ctrl_a_ff <= ROUTE_A_RST;
      route_ctrl_b_ff <= ROUTE_B_RST;
    end else begin
      port1_ctrl_ff <= nxt_port1_ctrl;
      port2_ctrl_ff <= nxt_port2_ctrl;
      port3_ctrl_ff <= nxt_port3_ctrl;
      route_ctrl_a_ff <= nxt_route_ctrl_a;
      route_ctrl_b_ff <= nxt_route_ctrl_b;
    end
  end

  // Pad inputs cross into the clock domain
  logic [23:0] pad_sync_q;
  wire [15:0] pin12_in = pad_sync_q[15:0];
  wire [7:0] pin3_in = pad_sync_q[23:16];

  pad_sync #(
    .WIDTH(24)
  ) u_pad_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({pad3_in, pad12_in}),
    .sync_out(pad_sync_q)
  );

  // Read path; unmapped addresses answer zero
  wire [31:0] pin_state = {8'h00, pin3_in, pin12_in};
  wire [31:0] rd_val = sel_p1 ? port1_ctrl_ff :
                       sel_p2 ? port2_ctrl_ff :
                       sel_p3 ? port3_ctrl_ff :
                       sel_state ? pin_state :
                       sel_a ? route_ctrl_a_ff :
                       sel_b ? route_ctrl_b_ff :
                       32'h0000_0000;
  wire [31:0] nxt_rdata = reg_rd ? rd_val : 32'h0000_0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // Routing fields
  wire opamp_out_pin_sel = route_ctrl_a_ff[OPAMP_SEL_BIT];
  wire opamp_out_route_en = route_ctrl_a_ff[OPAMP_EN_BIT];
  wire comparator_route_en = route_ctrl_a_ff[CMP_EN_BIT];
  wire [SEL_W-1:0] capture_pair_sel = route_ctrl_a_ff[CAP_SEL_LSB +: SEL_W];
  wire [SEL_W-1:0] pwm_pair_sel = route_ctrl_a_ff[PWM_SEL_LSB +: SEL_W];
  wire pwm1_route_en = route_ctrl_a_ff[PWM1_EN_BIT];
  wire pwm0_route_en = route_ctrl_a_ff[PWM0_EN_BIT];
  wire [SEL_W-1:0] twowire_pair_sel = route_ctrl_b_ff[TW_SEL_LSB +: SEL_W];
  wire twowire_route_en = route_ctrl_b_ff[TW_EN_BIT];
  wire [GRP_W-1:0] serial_periph_group_sel = route_ctrl_b_ff[SPI_SEL_LSB +: GRP_W];
  wire serial_periph_route_en = route_ctrl_b_ff[SPI_EN_BIT];
  wire [SEL_W-1:0] async_serial_pair_sel = route_ctrl_b_ff[UART_SEL_LSB +: SEL_W];
  wire async_serial_route_en = route_ctrl_b_ff[UART_EN_BIT];

  // Pair code n covers pins 2n and 2n+1, ports 1 then 2
  wire [15:0] pwm_even = PAIR_BASE << {pwm_pair_sel, 1'b0};
  wire [15:0] pwm_odd = PAIR_BASE << {pwm_pair_sel, 1'b1};
  wire [15:0] tw_pair = (PAIR_BASE << {twowire_pair_sel, 1'b0})
                      | (PAIR_BASE << {twowire_pair_sel, 1'b1});
  wire [15:0] uart_even = PAIR_BASE << {async_serial_pair_sel, 1'b0};
  wire [15:0] uart_odd = PAIR_BASE << {async_serial_pair_sel, 1'b1};
  wire [15:0] spi_group = GROUP_BASE << {serial_periph_group_sel, 2'b00};

  // Claims, each gated by its own enable
  wire [15:0] spi_claim = serial_periph_route_en ? spi_group : 16'h0000;
  wire [15:0] tw_claim = twowire_route_en ? tw_pair : 16'h0000;
  wire [15:0] uart_claim = async_serial_route_en ? (uart_even | uart_odd)
                                                 : 16'h0000;
  wire [15:0] cmp_claim = comparator_route_en ? CMP_PIN_MASK : 16'h0000;
  wire [15:0] pwm_claim = (pwm0_route_en ? pwm_even : 16'h0000)
                        | (pwm1_route_en ? pwm_odd : 16'h0000);

  // Per-pin values offered by each source
  logic [15:0] spi_pin_out;
  logic [15:0] spi_pin_oe;
  logic [15:0] tw_pin_out;
  logic [15:0] tw_pin_oe;
  logic [15:0] uart_pin_out;
  logic [15:0] uart_pin_oe;
  logic [15:0] cmp_pin_out;
  logic [15:0] cmp_pin_oe;
  logic [15:0] pwm_pin_out;

  genvar i;
  generate
    for (i = 0; i < PAIR_PINS; i++) begin : g_src
      // Groups are aligned, so the low bits give the role
      assign spi_pin_out[i] = serial_periph_out[i % 4];
      assign spi_pin_oe[i] = serial_periph_oe[i % 4];
      // Two-wire is open drain: low or released
      assign tw_pin_out[i] = 1'b0;
      assign tw_pin_oe[i] = twowire_oe[i % 2] | ~twowire_out[i % 2];
      // Receive pin is claimed but never driven
      assign uart_pin_out[i] = (i % 2 == 0) ? async_serial_tx : 1'b0;
      assign uart_pin_oe[i] = (i % 2 == 0);
      assign cmp_pin_out[i] = (i == CMP_OUT_PIN) ? comparator_out : 1'b0;
      assign cmp_pin_oe[i] = (i == CMP_OUT_PIN);
      assign pwm_pin_out[i] = (i % 2 == 0) ? pwm_output_zero : pwm_output_one;
    end
  endgenerate

  // Ordinary port values for ports 1 and 2
  wire [15:0] gpio12_out = {port2_ctrl_ff[PORT_DO_LSB +: PORT_W],
                            port1_ctrl_ff[PORT_DO_LSB +: PORT_W]};
  wire [15:0] gpio12_oe = {port2_ctrl_ff[PORT_OE_LSB +: PORT_W],
                           port1_ctrl_ff[PORT_OE_LSB +: PORT_W]};
  wire [15:0] gpio12_pu = {port2_ctrl_ff[PORT_PU_LSB +: PORT_W],
                           port1_ctrl_ff[PORT_PU_LSB +: PORT_W]};

  logic [15:0] arb_out;
  logic [15:0] arb_oe;
  logic [15:0] arb_claimed;

  pin_drive_arbiter #(
    .PINS(PAIR_PINS)
  ) u_arbiter (
    .spi_claim(spi_claim),
    .spi_out(spi_pin_out),
    .spi_oe(spi_pin_oe),
    .tw_claim(tw_claim),
    .tw_out(tw_pin_out),
    .tw_oe(tw_pin_oe),
    .uart_claim(uart_claim),
    .uart_out(uart_pin_out),
    .uart_oe(uart_pin_oe),
    .cmp_claim(cmp_claim),
    .cmp_out(cmp_pin_out),
    .cmp_oe(cmp_pin_oe),
    .pwm_claim(pwm_claim),
    .pwm_out(pwm_pin_out),
    .gpio_out(gpio12_out),
    .gpio_oe(gpio12_oe),
    .drive_out(arb_out),
    .drive_oe(arb_oe),
    .claimed(arb_claimed)
  );

  // Pull-ups stay off on pins a peripheral owns
  wire [15:0] nxt_pad12_pullup = gpio12_pu & ~arb_claimed;

  // Port 3: op-amp on pin 0 or 1, else the port registers
  wire [7:0] opamp_mask = opamp_out_route_en ?
                          (opamp_out_pin_sel ? 8'h02 : 8'h01) : 8'h00;
  wire [7:0] gpio3_out = port3_ctrl_ff[PORT_DO_LSB +: PORT_W];
  wire [7:0] gpio3_oe = port3_ctrl_ff[PORT_OE_LSB +: PORT_W];
  wire [7:0] gpio3_pu = port3_ctrl_ff[PORT_PU_LSB +: PORT_W];
  wire [7:0] nxt_pad3_out = (gpio3_out & ~opamp_mask)
                          | (opamp_mask & {8{opamp_dig_out}});
  wire [7:0] nxt_pad3_oe = gpio3_oe | opamp_mask;
  wire [7:0] nxt_pad3_pullup = gpio3_pu & ~opamp_mask;

  // Inputs to peripherals; capture has no enable and always taps
  wire [3:0] cap_even_idx = {capture_pair_sel, 1'b0};
  wire [3:0] cap_odd_idx = {capture_pair_sel, 1'b1};
  wire nxt_capture_one = pin12_in[cap_even_idx];
  wire nxt_capture_two = pin12_in[cap_odd_idx];
  wire [3:0] tw_scl_idx = {twowire_pair_sel, 1'b0};
  wire [3:0] tw_sda_idx = {twowire_pair_sel, 1'b1};
  wire [1:0] nxt_twowire_in = twowire_route_en ?
                              {pin12_in[tw_sda_idx], pin12_in[tw_scl_idx]}
                            : {TW_IDLE, TW_IDLE};
  wire [3:0] uart_rx_idx = {async_serial_pair_sel, 1'b1};
  wire nxt_async_rx = async_serial_route_en ? pin12_in[uart_rx_idx]
                                            : UART_RX_IDLE;
  wire [3:0] spi_grp_pins = pin12_in[{serial_periph_group_sel, 2'b00} +: 4];
  wire [3:0] nxt_spi_in = serial_periph_route_en ? spi_grp_pins : SPI_IDLE;
  wire [7:0] nxt_cmp_connect = comparator_route_en ? 8'h7F : 8'h00;

  // Registered outputs; one cycle of latency keeps pads glitch free
  logic [15:0] pad12_out_ff;
  logic [15:0] pad12_oe_ff;
  logic [15:0] pad12_pullup_ff;
  logic [7:0] pad3_out_ff;
  logic [7:0] pad3_oe_ff;
  logic [7:0] pad3_pullup_ff;
  logic [7:0] cmp_connect_ff;
  logic cap_one_ff;
  logic cap_two_ff;
  logic [1:0] twowire_in_ff;
  logic [3:0] spi_in_ff;
  logic async_rx_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pad12_out_ff <= 16'h0000;
      pad12_oe_ff <= 16'h0000;
      pad12_pullup_ff <= 16'h0000;
      pad3_out_ff <= 8'h00;
      pad3_oe_ff <= 8'h00;
      pad3_pullup_ff <= 8'h00;
    end else begin
      pad12_out_ff <= arb_out;
      pad12_oe_ff <= arb_oe;
      pad12_pullup_ff <= nxt_pad12_pullup;
      pad3_out_ff <= nxt_pad3_out;
      pad3_oe_ff <= nxt_pad3_oe;
      pad3_pullup_ff <= nxt_pad3_pullup;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_connect_ff <= 8'h00;
      cap_one_ff <= CAP_IDLE;
      cap_two_ff <= CAP_IDLE;
      twowire_in_ff <= {TW_IDLE, TW_IDLE};
      spi_in_ff <= SPI_IDLE;
      async_rx_ff <= UART_RX_IDLE;
    end else begin
      cmp_connect_ff <= nxt_cmp_connect;
      cap_one_ff <= nxt_capture_one;
      cap_two_ff <= nxt_capture_two;
      twowire_in_ff <= nxt_twowire_in;
      spi_in_ff <= nxt_spi_in;
      async_rx_ff <= nxt_async_rx;
    end
  end

  assign pad12_out = pad12_out_ff;
  assign pad12_oe = pad12_oe_ff;
  assign pad12_pullup = pad12_pullup_ff;
  assign pad3_out = pad3_out_ff;
  assign pad3_oe = pad3_oe_ff;
  assign pad3_pullup = pad3_pullup_ff;
  assign comparator_pad_connect = cmp_connect_ff;
  assign capture_input_one = cap_one_ff;
  assign capture_input_two = cap_two_ff;
  assign twowire_in = twowire_in_ff;
  assign serial_periph_in = spi_in_ff;
  assign async_serial_rx = async_rx_ff;
endmodule : peripheral_pin_router

// ===== bench/pad_world.sv
// Board and pad model on the far side of the pin router
`timescale 1ns/1ps
module pad_world #(
  parameter int W = 16
) (
  // Clock
  input wire logic clk,
  // Chip side
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pin_pu,
  // Board side
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_lvl,
  output logic [W-1:0] pin_in
);
  // Floating pins toggle; no check may lean on them
  logic [W-1:0] float_ff = '0;
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
                | (~pin_oe & ~ext_en & (pin_pu | float_ff));
endmodule : pad_world

// ===== bench/pin_router_sva.sv
// Assertion checker for the peripheral pin router
`timescale 1ns/1ps
module pin_router_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [pin_router_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pin_router_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pin_router_pkg::DATA_W-1:0] reg_rdata,
  // Pads
  input wire logic [15:0] pad12_in,
  input wire logic [15:0] pad12_out,
  input wire logic [15:0] pad12_oe,
  input wire logic [7:0] pad3_out,
  input wire logic [7:0] pad3_oe,
  // Peripherals
  input wire logic opamp_dig_out,
  input wire logic [7:0] comparator_pad_connect,
  input wire logic capture_input_one,
  input wire logic pwm_output_zero,
  input wire logic [1:0] twowire_out,
  input wire logic [1:0] twowire_oe,
  input wire logic [3:0] serial_periph_oe,
  input wire logic async_serial_tx,
  input wire logic async_serial_rx
);
  import pin_router_pkg::*;
  logic [31:0] a_ff, b_ff, p1_ff, p2_ff, p3_ff;
  logic [2:0] warm_ff;
  // Register shadows
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {a_ff, b_ff, p1_ff, p2_ff, p3_ff} <= '0;
      warm_ff <= '0;
    end else begin
      if (warm_ff != 3'h7) warm_ff <= warm_ff + 3'h1;
      if (reg_wr) case (reg_addr)
        ROUTE_CTRL_A_OFS: a_ff <= reg_wdata & 32'h000D_00FF;
        ROUTE_CTRL_B_OFS: b_ff <= reg_wdata & 32'h000F_007F;
        PORT1_CTRL_OFS: p1_ff <= reg_wdata & PORT_WR_MASK;
        PORT2_CTRL_OFS: p2_ff <= reg_wdata & PORT_WR_MASK;
        PORT3_CTRL_OFS: p3_ff <= reg_wdata & PORT_WR_MASK;
        default: ;
      endcase
    end
  end
  wire [3:0] pwm_ev = {a_ff[4:2], 1'b0};
  wire [3:0] cap_ev = {a_ff[7:5], 1'b0};
  wire [3:0] tw_ev = {b_ff[19:17], 1'b0};
  wire [3:0] ua_ev = {b_ff[3:1], 1'b0};
  wire [3:0] sp_lo = {b_ff[6:5], 2'b00};
  wire no_route = (a_ff & 32'h0005_0003) == '0 && (b_ff & 32'h0001_0011) == '0;
  wire hi_off = !b_ff[16] && !b_ff[4] && !b_ff[0] && !a_ff[16];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not cleared");
  a_read_back: assert property ($past(reg_rd && reg_addr == ROUTE_CTRL_B_OFS) |->
    reg_rdata == $past(b_ff)) else $error("read back wrong");
  a_gpio_follow: assert property ($past(no_route) |->
    pad12_oe == $past({p2_ff[7:0], p1_ff[7:0]}) && pad12_out == $past({p2_ff[15:8], p1_ff[15:8]})
    && pad3_oe == $past(p3_ff[7:0])) else $error("gpio pins wrong");
  a_opamp_pin: assert property ($past(a_ff[18]) |-> pad3_oe[$past(a_ff[19])] &&
    pad3_out[$past(a_ff[19])] == $past(opamp_dig_out)) else $error("op-amp pin wrong");
  a_cmp_connect: assert property (comparator_pad_connect ==
    ($past(a_ff[16]) ? 8'h7F : 8'h00)) else $error("cmp connect wrong");
  a_capture_pick: assert property (warm_ff[2] |-> capture_input_one ==
    (($past(pad12_in, 3) >> $past(cap_ev)) & 16'h0001)) else $error("capture pin wrong");
  a_pwm_pair: assert property ($past(a_ff[0] && hi_off) |-> pad12_oe[$past(pwm_ev)] &&
    pad12_out[$past(pwm_ev)] == $past(pwm_output_zero)) else $error("pwm pin wrong");
  a_twowire_od: assert property ($past(b_ff[16] && !b_ff[4]) |->
    pad12_oe[$past(tw_ev)] == $past(twowire_oe[0] || !twowire_out[0]) &&
    pad12_oe[$past(tw_ev) + 4'h1] == $past(twowire_oe[1] || !twowire_out[1]))
    else $error("two-wire pin wrong");
  a_spi_group: assert property ($past(b_ff[4]) |->
    pad12_oe[$past(sp_lo) +: 4] == $past(serial_periph_oe)) else $error("spi group wrong");
  a_uart_pair: assert property ($past(b_ff[0] && !b_ff[4] && !b_ff[16]) |->
    pad12_oe[$past(ua_ev)] && pad12_out[$past(ua_ev)] == $past(async_serial_tx) &&
    !pad12_oe[$past(ua_ev) + 4'h1]) else $error("uart pins wrong");
  a_rx_idle: assert property (!$past(b_ff[0]) |-> async_serial_rx)
    else $error("rx not idle");
  c_spi_over_uart: cover property (b_ff[4] && b_ff[0]);
  c_pwm_both: cover property (a_ff[1] && a_ff[0]);
  c_opamp_hi: cover property (a_ff[18] && a_ff[19]);
endmodule : pin_router_sva

bind peripheral_pin_router pin_router_sva u_sva (
  .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .pad12_in, .pad12_out, .pad12_oe, .pad3_out, .pad3_oe, .opamp_dig_out,
  .comparator_pad_connect, .capture_input_one, .pwm_output_zero, .twowire_out,
  .twowire_oe, .serial_periph_oe, .async_serial_tx, .async_serial_rx
);

// ===== bench/tb.sv
// Self-checking testbench for the peripheral pin router
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
  import pin_router_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [15:0] pad12_in, pad12_out, pad12_oe, pad12_pullup, ext_en = '0, ext_lvl = '0;
  logic [7:0] pad3_in, pad3_out, pad3_oe, pad3_pullup, comparator_pad_connect;
  logic opamp_dig_out = 1'b0, comparator_out = 1'b0, async_serial_tx = 1'b0;
  logic pwm_output_zero = 1'b0, pwm_output_one = 1'b0;
  logic capture_input_one, capture_input_two, async_serial_rx;
  logic [1:0] twowire_out = '0, twowire_oe = '0, twowire_in;
  logic [3:0] serial_periph_out = '0, serial_periph_oe = '0, serial_periph_in;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  always #4 clk = ~clk;
  peripheral_pin_router dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pad12_in, .pad12_out, .pad12_oe, .pad12_pullup, .pad3_in, .pad3_out,
    .pad3_oe, .pad3_pullup, .opamp_dig_out, .comparator_out, .comparator_pad_connect,
    .capture_input_one, .capture_input_two, .pwm_output_zero, .pwm_output_one,
    .twowire_out, .twowire_oe, .twowire_in, .serial_periph_out, .serial_periph_oe,
    .serial_periph_in, .async_serial_tx, .async_serial_rx);
  pad_world #(.W(16)) board12 (.clk, .pin_out(pad12_out), .pin_oe(pad12_oe),
    .pin_pu(pad12_pullup), .ext_en, .ext_lvl, .pin_in(pad12_in));
  pad_world #(.W(8)) board3 (.clk, .pin_out(pad3_out), .pin_oe(pad3_oe),
    .pin_pu(pad3_pullup), .ext_en(ext_en[7:0]), .ext_lvl(ext_lvl[15:8]), .pin_in(pad3_in));
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stand one cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task t_regs;
    rd(ROUTE_CTRL_A_OFS, 32'h0);
    rd(ROUTE_CTRL_B_OFS, 32'h0);
    wr(ROUTE_CTRL_A_OFS, 32'hFFFF_FFFF);
    wr(ROUTE_CTRL_B_OFS, 32'hFFFF_FFFF);
    wr(8'h80, 32'hFFFF_FFFF);
    rd(ROUTE_CTRL_A_OFS, 32'h000D_00FF);
    rd(ROUTE_CTRL_B_OFS, 32'h000F_007F);
    rd(8'h80, 32'h0);
    wr(ROUTE_CTRL_A_OFS, 32'h0);
    wr(ROUTE_CTRL_B_OFS, 32'h0);
  endtask : t_regs
  task t_gpio;
    wr(PORT1_CTRL_OFS, 32'h00A5_3CFF);
    wr(PORT2_CTRL_OFS, 32'h005A_C300);
    settle(1);
    `CHK(pad12_oe, 16'h00FF)
    `CHK(pad12_out, 16'hC33C)
    `CHK(pad12_pullup, 16'h5AA5)
    wr(PORT1_CTRL_OFS, 32'h0);
    wr(PORT2_CTRL_OFS, 32'h0);
  endtask : t_gpio
  task t_pwm;
    @(posedge clk);
    pwm_output_zero <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(ROUTE_CTRL_A_OFS, {27'h0, c[2:0], 2'b11});
      settle(1);
      `CHK(pad12_oe[2*c +: 2], 2'b11)
      `CHK(pad12_out[2*c +: 2], 2'b01)
      wr(ROUTE_CTRL_A_OFS, {27'h0, c[2:0], 2'b01});
      settle(1);
      `CHK(pad12_oe[2*c +: 2], 2'b01)
    end
  endtask : t_pwm
  task t_cap;
    for (int c = 0; c < 8; c++) begin
      wr(ROUTE_CTRL_A_OFS, {24'h0, c[2:0], 5'h0});
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        ext_en <= 16'hFFFF;
        ext_lvl <= k ? 16'hAAAA : 16'h5555;
        settle(4);
        `CHK({capture_input_two, capture_input_one}, k ? 2'b10 : 2'b01)
      end
    end
  endtask : t_cap
  task t_tw;
    @(posedge clk);
    ext_lvl <= 16'h0000;
    twowire_out <= 2'b10;
    for (int c = 0; c < 8; c++) begin
      wr(ROUTE_CTRL_B_OFS, {12'h0, c[2:0], 1'b1, 16'h0});
      settle(4);
      `CHK(pad12_oe[2*c +: 2], 2'b01)
      `CHK(twowire_in, 2'b00)
    end
    wr(ROUTE_CTRL_B_OFS, 32'h0);
    settle(4);
    `CHK(twowire_in, 2'b11)
    `CHK(pad12_oe, 16'h0)
  endtask : t_tw
  // Group outranks async serial
  task t_spi;
    @(posedge clk);
    serial_periph_out <= 4'b1010;
    serial_periph_oe <= 4'b1011;
    ext_lvl <= 16'h4444;
    for (int g = 0; g < 4; g++) begin
      wr(ROUTE_CTRL_B_OFS, {25'h0, g[1:0], 1'b1, g[1:0], 2'b01});
      settle(4);
      `CHK(pad12_oe[4*g +: 4], 4'b1011)
      `CHK(pad12_out[4*g +: 4] & 4'b1011, 4'b1010)
      `CHK(serial_periph_in[2], 1'b1)
    end
    wr(ROUTE_CTRL_B_OFS, 32'h0);
    settle(4);
    `CHK(serial_periph_in, 4'h1)
    `CHK(pad12_oe, 16'h0)
  endtask : t_spi
  task t_uart;
    @(posedge clk);
    async_serial_tx <= 1'b1;
    ext_lvl <= 16'h0000;
    for (int c = 0; c < 8; c++) begin
      wr(ROUTE_CTRL_B_OFS, {28'h0, c[2:0], 1'b1});
      settle(4);
      `CHK(pad12_oe[2*c +: 2], 2'b01)
      `CHK(pad12_out[2*c], 1'b1)
      `CHK(async_serial_rx, 1'b0)
    end
    wr(ROUTE_CTRL_B_OFS, 32'h0);
    settle(4);
    `CHK(async_serial_rx, 1'b1)
  endtask : t_uart
  task t_analog;
    @(posedge clk);
    opamp_dig_out <= 1'b1;
    comparator_out <= 1'b1;
    wr(PORT3_CTRL_OFS, 32'h00FF_0000);
    for (int s = 0; s < 2; s++) begin
      wr(ROUTE_CTRL_A_OFS, {12'h0, s[0], 1'b1, 18'h0});
      settle(1);
      `CHK(pad3_pullup, s ? 8'hFD : 8'hFE)
      `CHK(pad3_oe[1:0], s ? 2'b10 : 2'b01)
      `CHK(pad3_out[s], 1'b1)
    end
    wr(ROUTE_CTRL_A_OFS, 32'h0001_000F);
    settle(1);
    `CHK(comparator_pad_connect, 8'h7F)
    `CHK(pad12_oe[7:6], 2'b10)
    `CHK(pad12_out[7], 1'b1)
    wr(ROUTE_CTRL_A_OFS, 32'h0);
    settle(1);
    `CHK(pad3_oe, 8'h00)
    `CHK(comparator_pad_connect, 8'h00)
  endtask : t_analog
  task tally_and_finish;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_gpio;
    t_pwm;
    t_cap;
    t_tw;
    t_spi;
    t_uart;
    t_analog;
    tally_and_finish;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
endmodule : tb
